// File: dtr_defs.svh
// Timing constants for the DRAM command timing block
// Function
// - Write latency equals read latency minus one
// - Termination resyncs up to 8 clocks after exit
// - Termination update within 0 to 12 ns
// - Drive mode outputs within 0 to 12 ns
`ifndef DTR_DEFS_SVH
`define DTR_DEFS_SVH
`define DTR_CLK_PERIOD_PS        10000
`define DTR_MODE_SET_TERM_UPD_PS 12000
`define DTR_DRV_ADJ_OUT_DELAY_PS 12000
`define DTR_MODE_SET_TERM_UPD_CYC \
  ((`DTR_MODE_SET_TERM_UPD_PS / `DTR_CLK_PERIOD_PS) < 1 ? 1 : \
   (`DTR_MODE_SET_TERM_UPD_PS / `DTR_CLK_PERIOD_PS))
`define DTR_DRV_ADJ_OUT_DELAY_CYC \
  ((`DTR_DRV_ADJ_OUT_DELAY_PS / `DTR_CLK_PERIOD_PS) < 1 ? 1 : \
   (`DTR_DRV_ADJ_OUT_DELAY_PS / `DTR_CLK_PERIOD_PS))
`define DTR_TERM_PD_EXIT_LAG_CYC 8
`define DTR_WL_OFFSET            1
`endif

// File: dtr_pkg.sv
// Types for the DRAM command timing block
package dtr_pkg;
  typedef enum logic [2:0] {
    DTR_CMD_NOP, DTR_CMD_WRITE, DTR_CMD_READ, DTR_CMD_MODE_SET,
    DTR_CMD_PD_ENTER, DTR_CMD_PD_EXIT, DTR_CMD_DRV_ADJ
  } dtr_cmd_e;
  typedef struct packed {
    dtr_cmd_e   cmd;
    logic       term_en;
  } dtr_req_s;
  typedef logic [2:0] dtr_lat_t;
endpackage

// File: dtr_delay.sv
// Countdown timer that fires a pulse a set number of clocks after start
`timescale 1ns/1ps
module dtr_delay (
  input  wire logic       clk_i,     // Clock
  input  wire logic       reset_n_i, // Async reset, active low
  input  wire logic       start_i,   // Restart countdown
  input  wire logic [7:0] count_i,   // Clocks until done
  output logic            busy_o,    // Countdown running
  output logic            done_o     // One-cycle done pulse
);
  logic [7:0] cnt_r;
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      cnt_r  <= 8'h00;
      done_o <= 1'b0;
    end else begin
      done_o <= (cnt_r == 8'h01) && !start_i;
      if (start_i) begin
        cnt_r <= count_i;
      end else if (cnt_r != 8'h00) begin
        cnt_r <= cnt_r - 8'h01;
      end
    end
  end
  assign busy_o = (cnt_r != 8'h00);
endmodule

// File: dtr_core.sv
// Device-side latency, termination and drive-mode timing logic
`timescale 1ns/1ps
`include "dtr_defs.svh"
module dtr_core (
  input  wire logic           clk_i,             // Clock, 100 MHz
  input  wire logic           reset_n_i,         // Async reset, active low
  input  dtr_pkg::dtr_req_s   req_i,             // Decoded command
  input  dtr_pkg::dtr_lat_t   read_latency_i,    // Programmed read latency
  output dtr_pkg::dtr_lat_t   write_latency_o,   // Write latency clocks
  output logic                strobe_window_o,   // Write strobe edge due
  output logic                term_applied_o,    // Termination in force
  output logic                term_sync_o,       // Termination synchronous
  output logic                drv_mode_o         // Drive-mode outputs on
);
  import dtr_pkg::*;

  // ----------------------------------------------------------------
  // Write latency
  // ----------------------------------------------------------------
  dtr_lat_t wl_r;
  dtr_lat_t wl_cnt_r;
  logic     wr_pend_r;

  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      wl_r <= 3'h0;
    end else begin
      wl_r <= (read_latency_i == 3'h0) ? 3'h0 :
              read_latency_i - 3'(`DTR_WL_OFFSET);
    end
  end
  assign write_latency_o = wl_r;

  // Strobe edge marks clock WL after the write; WL of 0 marks clock 1, the same as WL of 1
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      wl_cnt_r        <= 3'h0;
      wr_pend_r       <= 1'b0;
      strobe_window_o <= 1'b0;
    end else begin
      strobe_window_o <= 1'b0;
      if (req_i.cmd == DTR_CMD_WRITE) begin
        wr_pend_r <= (wl_r > 3'h1);
        wl_cnt_r  <= wl_r - 3'h1;
        strobe_window_o <= (wl_r <= 3'h1);
      end else if (wr_pend_r) begin
        wl_cnt_r <= wl_cnt_r - 3'h1;
        if (wl_cnt_r == 3'h1) begin
          wr_pend_r       <= 1'b0;
          strobe_window_o <= 1'b1;
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // Termination update after mode set
  // ----------------------------------------------------------------
  logic term_pend_r;
  logic term_busy;
  logic term_done;

  // Hold the requested value so a later request cannot tear the update
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      term_pend_r <= 1'b0;
    end else if (req_i.cmd == DTR_CMD_MODE_SET) begin
      term_pend_r <= req_i.term_en;
    end
  end

  dtr_delay u_term_delay (
    .clk_i     (clk_i),
    .reset_n_i (reset_n_i),
    .start_i   (req_i.cmd == DTR_CMD_MODE_SET),
    .count_i   (8'(`DTR_MODE_SET_TERM_UPD_CYC)),
    .busy_o    (term_busy),
    .done_o    (term_done)
  );

  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      term_applied_o <= 1'b0;
    end else if (term_done) begin
      term_applied_o <= term_pend_r;
    end
  end

  // ----------------------------------------------------------------
  // Termination resync after power-down exit
  // ----------------------------------------------------------------
  logic sync_busy;
  logic in_pd_r;

  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      in_pd_r <= 1'b0;
    end else if (req_i.cmd == DTR_CMD_PD_ENTER) begin
      in_pd_r <= 1'b1;
    end else if (req_i.cmd == DTR_CMD_PD_EXIT) begin
      in_pd_r <= 1'b0;
    end
  end

  dtr_delay u_sync_delay (
    .clk_i     (clk_i),
    .reset_n_i (reset_n_i),
    .start_i   (req_i.cmd == DTR_CMD_PD_EXIT),
    .count_i   (8'(`DTR_TERM_PD_EXIT_LAG_CYC)),
    .busy_o    (sync_busy),
    .done_o    ()
  );

  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      term_sync_o <= 1'b1;
    end else begin
      term_sync_o <= !in_pd_r && !sync_busy &&
                     (req_i.cmd != DTR_CMD_PD_EXIT) &&
                     (req_i.cmd != DTR_CMD_PD_ENTER);
    end
  end

  // ----------------------------------------------------------------
  // Drive-mode output
  // ----------------------------------------------------------------
  logic drv_done;
  logic drv_req_r;

  dtr_delay u_drv_delay (
    .clk_i     (clk_i),
    .reset_n_i (reset_n_i),
    .start_i   (req_i.cmd == DTR_CMD_DRV_ADJ),
    .count_i   (8'(`DTR_DRV_ADJ_OUT_DELAY_CYC)),
    .busy_o    (),
    .done_o    (drv_done)
  );

  // Any other mode set leaves drive mode, except one in the cycle drv_done fires
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      drv_req_r  <= 1'b0;
      drv_mode_o <= 1'b0;
    end else begin
      if (req_i.cmd == DTR_CMD_DRV_ADJ) begin
        drv_req_r <= 1'b1;
      end else if (req_i.cmd == DTR_CMD_MODE_SET) begin
        drv_req_r  <= 1'b0;
        drv_mode_o <= 1'b0;
      end
      if (drv_done && drv_req_r) begin
        drv_mode_o <= 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!reset_n_i);

  sequence mode_set_on_s;
    req_i.cmd == DTR_CMD_MODE_SET && req_i.term_en;
  endsequence

  sequence quiet_s;
    (req_i.cmd != DTR_CMD_MODE_SET && req_i.cmd != DTR_CMD_DRV_ADJ)[*2];
  endsequence

  wl_value_a: assert property (
    read_latency_i != 3'h0 ##1 read_latency_i == $past(read_latency_i)
    |-> write_latency_o == read_latency_i - 3'h1)
    else $error("write latency not read latency minus one");

  strobe_due_a: assert property (
    req_i.cmd == DTR_CMD_WRITE && wl_r == 3'h2 &&
    req_i.cmd != DTR_CMD_NOP
    ##1 req_i.cmd != DTR_CMD_WRITE
    |-> ##1 strobe_window_o)
    else $error("strobe edge not marked at write latency");

  term_update_a: assert property (
    mode_set_on_s ##1 quiet_s |=> term_applied_o)
    else $error("termination not applied within delay");

  term_resync_a: assert property (
    req_i.cmd == DTR_CMD_PD_EXIT |=> !term_sync_o [*8])
    else $error("termination resynced early after exit");

  drv_mode_a: assert property (
    req_i.cmd == DTR_CMD_DRV_ADJ ##1 quiet_s |=> drv_mode_o)
    else $error("drive mode outputs late");

  drv_off_a: assert property (
    req_i.cmd == DTR_CMD_MODE_SET |=> !drv_mode_o)
    else $error("drive mode not left on mode set");

  term_pd_a: assert property (
    in_pd_r |-> !term_sync_o)
    else $error("termination synchronous during power-down");
endmodule

// File: dtr_ctl_model.sv
// Controller model that issues commands with legal spacing
`timescale 1ns/1ps
module dtr_ctl_model (
  input  wire logic         clk_i, // Clock
  output dtr_pkg::dtr_req_s req_o  // Command to the device
);
  import dtr_pkg::*;
  // Four-clock spacing (three idle clocks) covers every short spacing, with margin for edge races
  localparam int GAP = 4;
  // Clock-level spacing only
  // Whole clocks, rounded up
  int cyc = 0;
  int last = -100;
  initial req_o = '{cmd: DTR_CMD_NOP, term_en: 1'b0};
  always @(posedge clk_i) cyc <= cyc + 1;
  task automatic issue(input dtr_cmd_e c, input logic t);
    @(posedge clk_i);
    while (cyc - last < GAP) @(posedge clk_i);
    req_o <= '{cmd: c, term_en: t};
    last = cyc;
    @(posedge clk_i);
    // Termination value left steady between commands
    req_o <= '{cmd: DTR_CMD_NOP, term_en: t};
  endtask
endmodule

// File: dtr_core_tb.sv
// Self-checking bench for the device timing core
`timescale 1ns/1ps
`define CHK(a, b) begin comparisons++; if ((a) !== (b)) begin bad_count++; \
  $display("BAD t=%0t got %h exp %h", $time, a, b); end end
module dtr_core_tb;
  import dtr_pkg::*;
  logic     clk_i = 0;
  logic     reset_n_i = 0;
  dtr_lat_t rl = '0;
  dtr_req_s req;
  dtr_lat_t wl;
  logic     strobe, term, sync, drv;
  int       bad_count = 0;
  int       comparisons = 0;
  int       cycles = 0;
  int       n, exp_lat, exp_wl;
  logic     t;
  dtr_core u_dtr_core (.clk_i(clk_i), .reset_n_i(reset_n_i), .req_i(req),
    .read_latency_i(rl), .write_latency_o(wl), .strobe_window_o(strobe),
    .term_applied_o(term), .term_sync_o(sync), .drv_mode_o(drv));
  dtr_ctl_model u_dtr_ctl_model (.clk_i(clk_i), .req_o(req));
  initial forever #5 clk_i = ~clk_i;
  // ---------------------------------------------------------------
  // Hang guard
  // ---------------------------------------------------------------
  always @(posedge clk_i) begin
    cycles++;
    if (cycles == 3000) begin
      bad_count++;
      end_of_test();
    end
  end
  task automatic end_of_test();
    $display("comparisons %0d mismatches %0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  task automatic step();
    @(posedge clk_i);
    #1;
  endtask
  task automatic check_reset();
    `CHK(wl, 3'h0)
    `CHK(strobe, 1'b0)
    `CHK(term, 1'b0)
    `CHK(sync, 1'b1)
    `CHK(drv, 1'b0)
  endtask
  // ---------------------------------------------------------------
  // Main sequence
  // ---------------------------------------------------------------
  initial begin
    void'($urandom(55718));
    repeat (3) @(posedge clk_i);
    #1;
    check_reset();
    @(posedge clk_i);
    reset_n_i <= 1'b1;
    // Every read latency, boundaries included
    for (int i = 0; i < 8; i++) begin
      @(posedge clk_i);
      rl <= dtr_lat_t'(i);
      exp_wl = (i == 0) ? 0 : i - 1;
      exp_lat = (exp_wl <= 1) ? 1 : exp_wl;
      step();
      `CHK(wl, dtr_lat_t'(exp_wl))
      u_dtr_ctl_model.issue(DTR_CMD_WRITE, 1'b0);
      #1;
      n = 1;
      while (strobe !== 1'b1 && n < 10) begin
        step();
        n++;
      end
      `CHK(n, exp_lat)
      step();
      `CHK(strobe, 1'b0)
      repeat ($urandom_range(3)) @(posedge clk_i);
    end
    $display("test latency done");
    // Termination updates, random values
    for (int i = 0; i < 6; i++) begin
      t = (i < 2) ? i[0] : 1'($urandom);
      u_dtr_ctl_model.issue(DTR_CMD_DRV_ADJ, t);
      step();
      step();
      `CHK(drv, 1'b1)
      u_dtr_ctl_model.issue(DTR_CMD_MODE_SET, t);
      step();
      step();
      `CHK(term, t)
      `CHK(drv, 1'b0)
    end
    $display("test termination done");
    u_dtr_ctl_model.issue(DTR_CMD_PD_ENTER, t);
    repeat (3) step();
    `CHK(sync, 1'b0)
    u_dtr_ctl_model.issue(DTR_CMD_PD_EXIT, t);
    for (int k = 1; k <= 8; k++) begin
      step();
      `CHK(sync, 1'b0)
    end
    step();
    `CHK(sync, 1'b1)
    $display("test power-down done");
    @(posedge clk_i);
    reset_n_i <= 0;
    step();
    check_reset();
    @(posedge clk_i);
    reset_n_i <= 1'b1;
    $display("test reset done");
    end_of_test();
  end
endmodule
